// ==== core/crcsd_pkg.sv ====
// crcsd_pkg: constants and types of the crc engine with program memory scanner
// Contract
// [R1] watchdog counts whatever the scanner does; long scans can reach its timeout
// [R2] debug halt freezes the scanner until user execution resumes
// [R3] scan control and current address stay readable while halted
// [R4] external halt before a concurrent or triggered scan defers the scan
// [R5] pc breakpoint lets the pending scan cycle finish before debug entry
// [R6] data breakpoint postpones a scan requested in that cycle until debug exit; the code postpones only concurrent and triggered scans, not burst or peek
// [R7] single step lets a ready scan read flash before debug re-entry
// [R8] scan stalling a software breakpoint finishes before debug entry
// [R9] external halt suspends a burst; it resumes where it stopped
// [R10] burst started under breakpoint begins only at debug exit, then completes
// [R11] peek access lost to debug entry happens after debug exit
// [R12] crc enable releases the engine from reset; clear holds it idle
// [R13] crc run starts the serial shifter; zero stops it
// [R14] busy reads one while a word is pending or shifting
// [R15] zero augment set computes as if zeros were appended to data
// [R16] direction one shifts right lsb first; zero shifts left msb first
// [R17] full reads one until the held word moves into the shifter
// [R18] control 1 upper nibble is data length minus one
// [R19] control 1 lower nibble is polynomial length minus one
// [R20] writing the input low byte loads the word and starts processing
// [R21] result high write updates the accumulator; read returns it
// [R22] running scanner loads flash words whenever the engine needs one
// [R23] scanner waits for engine ready, which needs crc run, before fetching
// [R24] each step shifts one bit in and xors polynomial on feedback
// [R25] control 0 bits 3 and 2 read zero and ignore writes
package crcsd_pkg;
  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h1;
  localparam logic [3:0] OFS_INH = 4'h2;
  localparam logic [3:0] OFS_INL = 4'h3;
  localparam logic [3:0] OFS_RESH = 4'h4;
  localparam logic [3:0] OFS_RESL = 4'h5;
  localparam logic [3:0] OFS_XORH = 4'h6;
  localparam logic [3:0] OFS_XORL = 4'h7;
  localparam logic [3:0] OFS_SCTL = 4'h8;
  localparam logic [3:0] OFS_SCURL = 4'h9;
  localparam logic [3:0] OFS_SCURH = 4'hA;
  localparam logic [3:0] OFS_SENDL = 4'hB;
  localparam logic [3:0] OFS_SENDH = 4'hC;
  localparam logic [3:0] OFS_WDTCLR = 4'hD;
  // ==========================================================
  // field positions and reset values
  localparam int B_EN = 7;
  localparam int B_RUN = 6;
  localparam int B_AUG = 4;
  localparam int B_INTM = 3;
  localparam int B_DIR = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] ACC_RST = 16'h0000;
  localparam int unsigned WDT_CYCLES_DEF = 65536;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SCAN_CONC = 2'h0, SCAN_BURST = 2'h1, SCAN_PEEK = 2'h2, SCAN_TRIG = 2'h3
  } crcsd_mode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } crcsd_bus_t;
  typedef struct packed {
    logic halted;
    logic ext_halt;
    logic pc_bp;
    logic data_bp;
    logic step;
    logic software_breakpoint;
    logic idle_cycle;
  } crcsd_dbg_t;
  typedef struct packed {
    logic en;
    logic run;
    logic augment;
    logic dir_right;
    logic [3:0] data_length_field;
    logic [3:0] poly_length_field;
    logic [15:0] poly;
  } crcsd_cfg_t;
endpackage

// ==== core/crcsd_crc.sv ====
// crcsd_crc: data holding register, serial shifter and accumulator
`timescale 1ns/100ps
module crcsd_crc (
  input wire logic clk,
  input wire logic rst_n,
  input wire crcsd_pkg::crcsd_cfg_t cfg,
  input wire logic load,
  input wire logic [15:0] load_word,
  input wire logic acc_wr_hi,
  input wire logic acc_wr_lo,
  input wire logic [7:0] acc_wdata,
  output logic [15:0] acc,
  output logic busy,
  output logic full,
  output logic ready
);
  import crcsd_pkg::*;
  logic [15:0] data_q, shift_q, acc_q;
  logic full_q, active_q, take, step, dbit;
  logic [3:0] cnt_q;

  function automatic logic [15:0] crc_step(logic [15:0] a, logic b, crcsd_cfg_t c);
    logic [15:0] mask;
    logic [15:0] nxt;
    logic fb;
    mask = 16'hFFFF >> (4'hF - c.poly_length_field); // R19
    if (c.dir_right) begin // R16
      fb = c.augment ? (a[0] ^ b) : a[0]; // R15
      nxt = (a & mask) >> 1;
      if (!c.augment) nxt[c.poly_length_field] = b;
    end else begin
      fb = c.augment ? (a[c.poly_length_field] ^ b) : a[c.poly_length_field];
      nxt = {a[14:0], c.augment ? 1'b0 : b};
    end
    crc_step = (nxt ^ (fb ? c.poly : 16'h0000)) & mask; // R24
  endfunction

  assign take = cfg.en && cfg.run && full_q && !active_q; // R13
  assign step = cfg.en && cfg.run && active_q;
  assign dbit = cfg.dir_right ? shift_q[0] : shift_q[cfg.data_length_field];
  assign acc = acc_q;
  assign busy = full_q || active_q; // R14
  assign full = full_q;
  assign ready = cfg.en && cfg.run && !full_q;

  always_ff @(posedge clk) begin
    if (!rst_n || !cfg.en) begin // R12
      full_q <= 1'b0;
      data_q <= 16'h0000;
    end else if (load) begin // R20
      full_q <= 1'b1;
      data_q <= load_word;
    end else if (take) begin // R17
      full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !cfg.en) begin
      active_q <= 1'b0;
      cnt_q <= 4'h0;
      shift_q <= 16'h0000;
    end else if (take) begin
      active_q <= 1'b1;
      cnt_q <= cfg.data_length_field; // R18
      shift_q <= data_q;
    end else if (step) begin
      shift_q <= cfg.dir_right ? (shift_q >> 1) : (shift_q << 1);
      cnt_q <= cnt_q - 4'h1;
      active_q <= (cnt_q != 4'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) acc_q <= ACC_RST;
    else if (acc_wr_hi) acc_q[15:8] <= acc_wdata; // R21
    else if (acc_wr_lo) acc_q[7:0] <= acc_wdata;
    else if (step) acc_q <= crc_step(acc_q, dbit, cfg);
  end

  AST_SHIFT_LEN: assert property (@(posedge clk) disable iff (!rst_n) // R18
    take |=> active_q && (cnt_q == $past(cfg.data_length_field))) else $error("bad shift length");
endmodule

// ==== core/crcsd_scan.sv ====
// crcsd_scan: scanner access sequencer with mode and debug gating
`timescale 1ns/100ps
module crcsd_scan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic crc_ready,
  input wire logic trig_edge,
  input wire crcsd_pkg::crcsd_mode_t mode,
  input wire crcsd_pkg::crcsd_dbg_t dbg,
  output logic rd,
  output logic load,
  output logic busy,
  output logic stall,
  output logic hold
);
  import crcsd_pkg::*;
  typedef enum logic [1:0] {SC_IDLE, SC_FETCH, SC_LOAD} crcsd_sst_t;
  crcsd_sst_t st_q, st_d;
  logic rd_q, stall_q, hold_q, trig_q, allowed, issue;

  always_comb begin
    unique case (mode)
      SCAN_PEEK: allowed = dbg.idle_cycle; // R11
      SCAN_BURST: allowed = !dbg.ext_halt; // R9
      SCAN_TRIG: allowed = trig_q && !dbg.ext_halt && !dbg.data_bp; // R4
      SCAN_CONC: allowed = !dbg.ext_halt && !dbg.data_bp; // R6
    endcase
  end

  // pc breakpoint, single step and software breakpoint do not block a scan
  assign issue = active && crc_ready && allowed && !dbg.halted && (st_q == SC_IDLE); // R23
  assign load = (st_q == SC_LOAD) && !dbg.halted; // R22
  assign busy = (st_q != SC_IDLE) || (active && crc_ready);
  assign rd = rd_q;
  assign stall = stall_q;
  assign hold = hold_q;

  always_comb begin
    st_d = st_q;
    if (!dbg.halted) begin // R2
      unique case (st_q)
        SC_IDLE: if (issue) st_d = SC_FETCH;
        SC_FETCH: st_d = SC_LOAD;
        SC_LOAD: st_d = SC_IDLE;
        default: st_d = SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= SC_IDLE;
      rd_q <= 1'b0;
      hold_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_q <= issue;
      hold_q <= (st_d != SC_IDLE); // R5 R7 R8
      stall_q <= (st_d != SC_IDLE) || ((mode == SCAN_BURST) && active && !dbg.ext_halt
        && !dbg.halted); // R10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) trig_q <= 1'b0;
    else if (trig_edge) trig_q <= 1'b1;
    else if (issue && (mode == SCAN_TRIG)) trig_q <= 1'b0;
  end
endmodule

// ==== core/crcsd_top.sv ====
// crcsd_top: crc engine with program memory scanner, debug freeze and watchdog
`timescale 1ns/100ps
module crcsd_top #(
  parameter int unsigned WDT_CYCLES = crcsd_pkg::WDT_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire crcsd_pkg::crcsd_bus_t REG_BUS,
  output logic [7:0] RDATA,
  output logic FLASH_RD,
  output logic [15:0] FLASH_ADDR,
  input wire logic [15:0] FLASH_DATA,
  input wire crcsd_pkg::crcsd_dbg_t DBG,
  input wire logic SCAN_TRIGGER,
  output logic CPU_STALL,
  output logic DBG_ENTRY_HOLD,
  output logic WDT_RESET
);
  import crcsd_pkg::*;

  localparam int WDT_W = $clog2(WDT_CYCLES);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

  // ==========================================================
  // state
  logic crc_en_q;
  logic crc_run_q;
  logic aug_q;
  logic dir_q;
  logic [3:0] data_length_field_q;
  logic [3:0] poly_length_field_q;
  logic [7:0] in_high_q;
  logic [7:0] in_low_q;
  logic [15:1] xor_q;
  logic scan_en_q;
  logic scan_run_q;
  logic intm_q;
  crcsd_mode_t mode_q;
  logic [15:0] scan_cur_q;
  logic [15:0] scan_end_q;
  logic [WDT_W-1:0] wdt_cnt_q;
  logic wdt_rst_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;

  // ==========================================================
  // wires
  crcsd_cfg_t cfg;
  logic [15:0] crc_acc;
  logic crc_busy;
  logic crc_full;
  logic crc_ready;
  logic scan_rd;
  logic scan_load;
  logic scan_busy;
  logic scan_stall;
  logic scan_hold;
  logic scan_active;
  logic scan_invalid;
  logic scan_last;
  logic trig_edge;
  logic crc_load;
  logic [15:0] crc_word;

  // ==========================================================
  // bus decode
  function automatic logic wr_hit(crcsd_bus_t b, logic [3:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  function automatic logic rd_hit(crcsd_bus_t b, logic [3:0] ofs);
    rd_hit = b.rd && (b.addr == ofs);
  endfunction

  // ==========================================================
  // crc control registers
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      crc_en_q <= CTRL_RST[B_EN];
      crc_run_q <= CTRL_RST[B_RUN];
      aug_q <= CTRL_RST[B_AUG];
      dir_q <= CTRL_RST[B_DIR];
    end else if (wr_hit(REG_BUS, OFS_CTRL0)) begin // R25
      crc_en_q <= REG_BUS.wdata[B_EN]; // R12
      crc_run_q <= REG_BUS.wdata[B_RUN]; // R13
      aug_q <= REG_BUS.wdata[B_AUG]; // R15
      dir_q <= REG_BUS.wdata[B_DIR]; // R16
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      data_length_field_q <= CTRL_RST[7:4];
      poly_length_field_q <= CTRL_RST[3:0];
    end else if (wr_hit(REG_BUS, OFS_CTRL1)) begin
      data_length_field_q <= REG_BUS.wdata[7:4]; // R18
      poly_length_field_q <= REG_BUS.wdata[3:0]; // R19
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      xor_q <= 15'h0000;
    end else if (wr_hit(REG_BUS, OFS_XORH)) begin
      xor_q[15:8] <= REG_BUS.wdata;
    end else if (wr_hit(REG_BUS, OFS_XORL)) begin
      xor_q[7:1] <= REG_BUS.wdata[7:1];
    end
  end

  // ==========================================================
  // input word registers, fed by software or the scanner
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      in_high_q <= 8'h00;
      in_low_q <= 8'h00;
    end else if (scan_load) begin // R22
      in_high_q <= FLASH_DATA[15:8];
      in_low_q <= FLASH_DATA[7:0];
    end else if (wr_hit(REG_BUS, OFS_INH)) begin
      in_high_q <= REG_BUS.wdata;
    end else if (wr_hit(REG_BUS, OFS_INL)) begin
      in_low_q <= REG_BUS.wdata;
    end
  end

  assign crc_load = scan_load || wr_hit(REG_BUS, OFS_INL); // R20
  assign crc_word = scan_load ? FLASH_DATA : {in_high_q, REG_BUS.wdata};

  assign cfg.en = crc_en_q;
  assign cfg.run = crc_run_q;
  assign cfg.augment = aug_q;
  assign cfg.dir_right = dir_q;
  assign cfg.data_length_field = data_length_field_q;
  assign cfg.poly_length_field = poly_length_field_q;
  assign cfg.poly = {xor_q, 1'b1};

  crcsd_crc u_crc (
    .clk(MCLK),
    .rst_n(NRST),
    .cfg(cfg),
    .load(crc_load),
    .load_word(crc_word),
    .acc_wr_hi(wr_hit(REG_BUS, OFS_RESH)),
    .acc_wr_lo(wr_hit(REG_BUS, OFS_RESL)),
    .acc_wdata(REG_BUS.wdata),
    .acc(crc_acc),
    .busy(crc_busy),
    .full(crc_full),
    .ready(crc_ready)
  );

  // ==========================================================
  // scanner control and addresses
  assign scan_invalid = scan_cur_q > scan_end_q;
  assign scan_last = scan_cur_q >= scan_end_q;
  assign scan_active = scan_en_q && scan_run_q && !scan_invalid;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      scan_en_q <= 1'b0;
      intm_q <= 1'b0;
      mode_q <= SCAN_CONC;
    end else if (wr_hit(REG_BUS, OFS_SCTL)) begin
      scan_en_q <= REG_BUS.wdata[B_EN];
      intm_q <= REG_BUS.wdata[B_INTM];
      mode_q <= crcsd_mode_t'(REG_BUS.wdata[1:0]);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) scan_run_q <= 1'b0;
    else if (wr_hit(REG_BUS, OFS_SCTL)) scan_run_q <= REG_BUS.wdata[B_RUN];
    else if (scan_load && scan_last) scan_run_q <= 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      scan_cur_q <= 16'h0000;
    end else if (scan_load) begin
      scan_cur_q <= scan_cur_q + 16'h0001;
    end else if (!scan_run_q && wr_hit(REG_BUS, OFS_SCURL)) begin
      scan_cur_q[7:0] <= REG_BUS.wdata;
    end else if (!scan_run_q && wr_hit(REG_BUS, OFS_SCURH)) begin
      scan_cur_q[15:8] <= REG_BUS.wdata;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      scan_end_q <= 16'h0000;
    end else if (wr_hit(REG_BUS, OFS_SENDL)) begin
      scan_end_q[7:0] <= REG_BUS.wdata;
    end else if (wr_hit(REG_BUS, OFS_SENDH)) begin
      scan_end_q[15:8] <= REG_BUS.wdata;
    end
  end

  // trigger comes from another clock: two stages, then edge detect
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= SCAN_TRIGGER;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_edge = trig_s2_q && !trig_s3_q;

  crcsd_scan u_scan (
    .clk(MCLK),
    .rst_n(NRST),
    .active(scan_active),
    .crc_ready(crc_ready),
    .trig_edge(trig_edge),
    .mode(mode_q),
    .dbg(DBG),
    .rd(scan_rd),
    .load(scan_load),
    .busy(scan_busy),
    .stall(scan_stall),
    .hold(scan_hold)
  );

  // ==========================================================
  // watchdog, independent of the scanner
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      wdt_cnt_q <= '0;
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= (wdt_cnt_q == WDT_LAST) && !wr_hit(REG_BUS, OFS_WDTCLR);
      if (wr_hit(REG_BUS, OFS_WDTCLR) || (wdt_cnt_q == WDT_LAST)) begin
        wdt_cnt_q <= '0;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + WDT_W'(1); // R1
      end
    end
  end

  // ==========================================================
  // read path, data one cycle after the strobe
  always_comb begin
    unique case (REG_BUS.addr)
      OFS_CTRL0: rd_mux = {crc_en_q, crc_run_q, crc_busy, aug_q, 2'b00, dir_q, crc_full}; // R14
      OFS_CTRL1: rd_mux = {data_length_field_q, poly_length_field_q};
      OFS_INH: rd_mux = in_high_q;
      OFS_INL: rd_mux = in_low_q;
      OFS_RESH: rd_mux = crc_acc[15:8]; // R21
      OFS_RESL: rd_mux = crc_acc[7:0];
      OFS_XORH: rd_mux = xor_q[15:8];
      OFS_XORL: rd_mux = {xor_q[7:1], 1'b0};
      OFS_SCTL: rd_mux = {scan_en_q, scan_run_q, scan_busy, scan_invalid, intm_q, 1'b0,
        mode_q}; // R3
      OFS_SCURL: rd_mux = scan_cur_q[7:0];
      OFS_SCURH: rd_mux = scan_cur_q[15:8];
      OFS_SENDL: rd_mux = scan_end_q[7:0];
      OFS_SENDH: rd_mux = scan_end_q[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) rdata_q <= 8'h00;
    else rdata_q <= REG_BUS.rd ? rd_mux : 8'h00;
  end

  assign RDATA = rdata_q;
  assign FLASH_RD = scan_rd;
  assign FLASH_ADDR = scan_cur_q;
  assign CPU_STALL = scan_stall;
  assign DBG_ENTRY_HOLD = scan_hold;
  assign WDT_RESET = wdt_rst_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  sequence s_scan_cycle;
    (FLASH_RD && DBG_ENTRY_HOLD) ##1 (scan_load && DBG_ENTRY_HOLD);
  endsequence

  AST_WDT_RUNS: assert property ( // R1
    !wr_hit(REG_BUS, OFS_WDTCLR) && (wdt_cnt_q != WDT_LAST) && (scan_busy || CPU_STALL)
    |=> wdt_cnt_q == $past(wdt_cnt_q) + 1'b1) else $error("watchdog stopped by scan");

  AST_HALT_FREEZE: assert property ( // R2
    DBG.halted |=> !FLASH_RD && !scan_load) else $error("scanner active while halted");

  AST_SCAN_READABLE: assert property ( // R3
    rd_hit(REG_BUS, OFS_SCURL) |=> RDATA == $past(scan_cur_q[7:0]))
    else $error("scan address not readable");

  AST_EXT_HALT_DEFER: assert property ( // R4
    DBG.ext_halt && (mode_q != SCAN_PEEK) && !scan_hold |=> !FLASH_RD)
    else $error("scan not deferred by external halt");

  AST_PC_BP_FINISH: assert property (@(posedge MCLK) disable iff (!NRST || DBG.halted) // R5
    FLASH_RD |-> s_scan_cycle) else $error("scan cycle not held through debug entry");

  AST_DATA_BP_DEFER: assert property ( // R6
    DBG.data_bp && ((mode_q == SCAN_CONC) || (mode_q == SCAN_TRIG)) && !scan_hold
    |=> !FLASH_RD) else $error("scan not postponed by data breakpoint");

  AST_PEEK_IDLE: assert property ( // R11
    FLASH_RD && (mode_q == SCAN_PEEK) |-> $past(DBG.idle_cycle))
    else $error("peek access outside idle cycle");

  AST_DISABLED: assert property ( // R12
    !crc_en_q |=> !crc_full && !crc_busy) else $error("engine active while disabled");

  AST_BUSY_FULL: assert property ( // R14
    crc_full |-> crc_busy) else $error("busy low with word pending");

  AST_FULL_SET: assert property ( // R17
    wr_hit(REG_BUS, OFS_INL) && crc_en_q |=> crc_full) else $error("full not set on load");

  AST_ACC_WRITE: assert property ( // R21
    wr_hit(REG_BUS, OFS_RESH) |=> crc_acc[15:8] == $past(REG_BUS.wdata))
    else $error("accumulator write lost");

  AST_SCAN_READY: assert property ( // R23
    FLASH_RD |-> $past(crc_ready) && $past(crc_run_q)) else $error("fetch without ready");

  AST_RSVD_ZERO: assert property ( // R25
    rd_hit(REG_BUS, OFS_CTRL0) |=> RDATA[3:2] == 2'b00) else $error("reserved bits set");
endmodule

// ==== verification/crcsd_flash_model.sv ====
// crcsd_flash_model: program flash answering the scanner's read requests
`timescale 1ns/100ps
module crcsd_flash_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [15:0] data
);
  // ==========================================================
  // word valid the cycle after a read, a changing pattern otherwise
  initial data = 16'h0000;
  always @(posedge clk) begin
    if (rd) begin
      data <= (addr * 16'h9E37) ^ 16'hC35A;
    end else begin
      data <= ~data;
    end
  end
endmodule

// ==== verification/tb.sv ====
// tb: self-checking bench of the crc engine and program memory scanner
`timescale 1ns/100ps
module tb;
  import crcsd_pkg::*;
  logic MCLK, NRST, FLASH_RD, CPU_STALL, DBG_ENTRY_HOLD, WDT_RESET, SCAN_TRIGGER;
  logic [7:0] RDATA, r, r2, c0;
  logic [15:0] FLASH_ADDR, FLASH_DATA, s, d, poly, acc0, a;
  crcsd_bus_t REG_BUS;
  crcsd_dbg_t DBG;
  int n_mismatch = 0, n_tests = 0, n_rd = 0, n0, n1, cyc = 0, last_wdt = -1, dl, pl;
  // ==========================================================
  // design and far side
  crcsd_top #(.WDT_CYCLES(16)) u_dut (.MCLK(MCLK), .NRST(NRST), .REG_BUS(REG_BUS),
    .RDATA(RDATA), .FLASH_RD(FLASH_RD), .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA),
    .DBG(DBG), .SCAN_TRIGGER(SCAN_TRIGGER), .CPU_STALL(CPU_STALL),
    .DBG_ENTRY_HOLD(DBG_ENTRY_HOLD), .WDT_RESET(WDT_RESET));
  crcsd_flash_model u_flash (.clk(MCLK), .rd(FLASH_RD), .addr(FLASH_ADDR), .data(FLASH_DATA));
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] wd);
    @(posedge MCLK);
    REG_BUS <= {ad, wd, 1'b1, 1'b0};
    @(posedge MCLK);
    REG_BUS <= '0;
  endtask
  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] rv);
    @(posedge MCLK);
    REG_BUS <= {ad, 8'h00, 1'b0, 1'b1};
    @(posedge MCLK);
    REG_BUS <= '0;
    #1 rv = RDATA;
  endtask
  task automatic wait_clr(input logic [3:0] ad, input int bn);
    logic [7:0] rv;
    for (int i = 0; i < 400; i++) begin
      rd_reg(ad, rv);
      if (rv[bn] === 1'b0) return;
    end
    n_mismatch++;
    summarize();
  endtask
  task automatic setup(input int dlv, input int plv, input logic [15:0] pv,
                       input logic [15:0] av, input logic [7:0] cv);
    wr_reg(OFS_CTRL0, 8'h80);
    wr_reg(OFS_CTRL1, 8'(dlv << 4 | plv));
    wr_reg(OFS_XORH, pv[15:8]);
    wr_reg(OFS_XORL, pv[7:0]);
    wr_reg(OFS_RESH, av[15:8]);
    wr_reg(OFS_RESL, av[7:0]);
    wr_reg(OFS_CTRL0, cv);
  endtask
  function automatic int crc_model(int ac, int dv, int dlv, int plv, int pv, bit rt, bit ag);
    int b, fb;
    for (int i = 0; i <= dlv; i++) begin
      b = rt ? (dv >> i) & 1 : (dv >> (dlv - i)) & 1;
      fb = (rt ? ac & 1 : (ac >> plv) & 1) ^ (ag ? b : 0);
      if (rt) ac = (ac >> 1) | (ag ? 0 : b << plv);
      else ac = ((ac << 1) | (ag ? 0 : b)) & ((1 << (plv + 1)) - 1);
      if (fb != 0) ac = ac ^ (pv & ((1 << (plv + 1)) - 1));
    end
    return ac;
  endfunction
  function automatic logic [15:0] fw(input logic [15:0] ad);
    return (ad * 16'h9E37) ^ 16'hC35A;
  endfunction
  // ==========================================================
  // monitors and free-running stimulus
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (FLASH_RD === 1'b1) n_rd <= n_rd + 1;
    if (WDT_RESET === 1'b1) begin
      if (last_wdt >= 0) chk(16'(cyc - last_wdt), 16'h0010);
      last_wdt <= cyc;
    end
    SCAN_TRIGGER <= (cyc % 7) < 3;
    DBG.idle_cycle <= 1'($urandom_range(1, 0));
  end
  // ==========================================================
  // main sequence
  initial begin
    NRST = 1'b0;
    REG_BUS = '0;
    DBG = '0;
    SCAN_TRIGGER = 1'b0;
    void'($urandom(32'h13af158c));
    repeat (5) @(posedge MCLK);
    NRST <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(4'(i == 6 ? 14 : i == 7 ? 8 : i), r);
      chk(r, 8'h00);
    end
    wr_reg(OFS_CTRL0, 8'hFF);
    rd_reg(OFS_CTRL0, r);
    chk(r, 8'hD2);
    wr_reg(OFS_CTRL1, 8'hA5);
    rd_reg(OFS_CTRL1, r);
    chk(r, 8'hA5);
    wr_reg(4'hE, 8'hFF);
    rd_reg(4'hE, r);
    chk(r, 8'h00);
    wr_reg(OFS_XORL, 8'hFF);
    rd_reg(OFS_XORL, r);
    chk(r, 8'hFE);
    wr_reg(OFS_CTRL0, 8'h00);
    wr_reg(OFS_INL, 8'h5A);
    rd_reg(OFS_CTRL0, r);
    chk(r, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 12; k++) begin
      dl = k == 0 ? 0 : $urandom_range(15, 0);
      pl = k == 1 ? 15 : $urandom_range(15, 1);
      poly = 16'($urandom) | 16'h0001;
      acc0 = 16'($urandom) & 16'((1 << (pl + 1)) - 1);
      d = 16'($urandom);
      c0 = {3'h4, k[1], 2'h0, k[0], 1'b0};
      setup(dl, pl, poly, acc0, c0);
      wr_reg(OFS_INH, d[15:8]);
      wr_reg(OFS_INL, d[7:0]);
      rd_reg(OFS_CTRL0, r);
      chk(r & 8'h21, 8'h21);
      wr_reg(OFS_CTRL0, c0 | 8'h40);
      wait_clr(OFS_CTRL0, 5);
      rd_reg(OFS_CTRL0, r);
      chk(r & 8'h21, 8'h00);
      rd_reg(OFS_RESH, r);
      rd_reg(OFS_RESL, r2);
      chk({r, r2}, 16'(crc_model(acc0, d, dl, pl, poly, k[0], k[1])));
    end
    $display("test crc words done");
    for (int m = 0; m < 4; m++) begin
      s = 16'($urandom_range(200, 0));
      a = s + 16'h000B;
      setup(15, 15, 16'h1021, 16'h0000, m == 0 ? 8'h80 : 8'hC0);
      wr_reg(OFS_SCURL, s[7:0]);
      wr_reg(OFS_SCURH, s[15:8]);
      wr_reg(OFS_SENDL, a[7:0]);
      wr_reg(OFS_SENDH, a[15:8]);
      n0 = n_rd;
      wr_reg(OFS_SCTL, 8'hC0 | 8'(m));
      if (m == 0) begin
        repeat (20) @(posedge MCLK);
        chk(16'(n_rd - n0), 16'h0000);
        wr_reg(OFS_CTRL0, 8'hC0);
      end
      for (int i = 0; i < 2000 && n_rd - n0 < 3; i++) @(posedge MCLK);
      if (n_rd - n0 < 3) begin
        n_mismatch++;
        summarize();
      end
      repeat (4) @(posedge MCLK);
      chk(16'({CPU_STALL, DBG_ENTRY_HOLD}), m == 1 ? 16'h0002 : 16'h0000);
      if (m[0]) DBG.ext_halt <= 1'b1;
      else DBG.halted <= 1'b1;
      repeat (2) @(posedge MCLK);
      n1 = n_rd;
      if (!m[0]) begin
        rd_reg(OFS_SCTL, r);
        chk(r & 8'hDF, 8'hC0 | 8'(m));
        rd_reg(OFS_SCURL, r);
        rd_reg(OFS_SCURH, r2);
        chk({r2, r}, s + 16'h0003);
      end
      repeat (40) @(posedge MCLK);
      chk(16'(n_rd - n1), 16'h0000);
      chk(16'({CPU_STALL, DBG_ENTRY_HOLD}), 16'h0000);
      if (m == 3) begin
        DBG.ext_halt <= 1'b0;
        DBG.data_bp <= 1'b1;
        repeat (30) @(posedge MCLK);
        chk(16'(n_rd - n1), 16'h0000);
      end
      DBG.ext_halt <= 1'b0;
      DBG.data_bp <= 1'b0;
      DBG.halted <= 1'b0;
      wait_clr(OFS_SCTL, 6);
      wait_clr(OFS_CTRL0, 5);
      chk(16'(n_rd - n0), 16'h000C);
      rd_reg(OFS_SCTL, r);
      chk(r & 8'hDF, 8'h90 | 8'(m));
      acc0 = 16'h0000;
      for (int i = 0; i < 12; i++) begin
        acc0 = 16'(crc_model(acc0, fw(s + 16'(i)), 15, 15, 16'h1021, 0, 0));
      end
      rd_reg(OFS_RESH, r);
      rd_reg(OFS_RESL, r2);
      chk({r, r2}, acc0);
      $display("test scan mode %0d done", m);
    end
    summarize();
  end
endmodule
